// File: pkg/pdma_pkg.sv
// Shared constants and types of the peripheral DMA engine.
// Assumes a single clock domain and a plain register port.
package pdma_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH    = 4;
  localparam int NUM_PER   = 8;
  localparam int CH_IDX_W  = 2;
  localparam int PER_IDX_W = 3;
  localparam int PID_W     = 4;
  localparam int ADDR_W    = 8;

  // ----------------------------------------------------------------
  // Register offsets inside one channel window
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_MAR  = 6'h00;
  localparam logic [5:0] OFS_PSR  = 6'h04;
  localparam logic [5:0] OFS_TCR  = 6'h08;
  localparam logic [5:0] OFS_MEMORY_POINTER_RELOAD = 6'h0C;
  localparam logic [5:0] OFS_TRANSFER_COUNTER_RELOAD = 6'h10;
  localparam logic [5:0] OFS_CR   = 6'h14;
  localparam logic [5:0] OFS_MR   = 6'h18;
  localparam logic [5:0] OFS_SR   = 6'h1C;
  localparam logic [5:0] OFS_ISR  = 6'h2C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CR_TEN      = 0;
  localparam int CR_TDIS     = 1;
  localparam int CR_ECLR     = 8;
  localparam int SR_TEN      = 0;
  localparam int ISR_RCZ     = 0;
  localparam int ISR_TRC     = 1;
  localparam int ISR_TRANSFER_ERROR_FLAG    = 2;
  localparam int PID_DIR_BIT = 3;

  // ----------------------------------------------------------------
  // Reset values and address steps
  // ----------------------------------------------------------------
  localparam logic [31:0] PTR_RST = 32'h0000_0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [3:0]  PSR_RST = 4'h0; // Arbitrary value
  localparam logic [2:0]  STEP_BYTE = 3'h1;
  localparam logic [2:0]  STEP_HALF = 3'h2;
  localparam logic [2:0]  STEP_WORD = 3'h4;

  typedef enum logic [1:0] {
    PDMA_SZ_BYTE = 2'h0,
    PDMA_SZ_HALF = 2'h1,
    PDMA_SZ_WORD = 2'h2
  } pdma_size_e;

  typedef enum logic [1:0] {
    PDMA_IDLE  = 2'b00,
    PDMA_PERRD = 2'b01,
    PDMA_MEM   = 2'b11,
    PDMA_DONE  = 2'b10
  } pdma_state_e;

endpackage

// File: verilog/pdma_prio_arb.sv
// Fixed priority picker over the channel requests.
// Assumes requests are already qualified by enable and counts.
`timescale 1ns/1ps
`default_nettype none
module pdma_prio_arb (
  input  wire logic [pdma_pkg::NUM_CH-1:0]   req,
  output logic      [pdma_pkg::CH_IDX_W-1:0] grantIdx,
  output logic                               grantValid
);
  import pdma_pkg::*;

  // ----------------------------------------------------------------
  // Lowest index wins
  // ----------------------------------------------------------------
  // Scan downward so the last hit is the lowest channel
  always_comb begin
    grantIdx   = '0;
    grantValid = 1'b0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (req[i]) begin
        grantIdx   = CH_IDX_W'(i);
        grantValid = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: verilog/pdma_size_align.sv
// Sizing of one data item and the pointer step for its size.
// Assumes the size code comes from the active channel's mode.
`timescale 1ns/1ps
`default_nettype none
module pdma_size_align (
  input  wire pdma_pkg::pdma_size_e sizeSel,
  input  wire logic [31:0]          rawData,
  output logic      [31:0]          sizedData,
  output logic      [2:0]           stepBytes
);
  import pdma_pkg::*;

  // ----------------------------------------------------------------
  // Zero fill above the item width
  // ----------------------------------------------------------------
  // Unused code 3 behaves as a word so nothing is lost
  wire isByte = (sizeSel == PDMA_SZ_BYTE);
  wire isHalf = (sizeSel == PDMA_SZ_HALF);

  assign sizedData = isByte ? {24'h00_0000, rawData[7:0]} :
                     isHalf ? {16'h0000, rawData[15:0]} :
                     rawData;
  assign stepBytes = isByte ? STEP_BYTE :
                     isHalf ? STEP_HALF : STEP_WORD;
endmodule
`default_nettype wire

// File: verilog/pdma_core.sv
// Peripheral DMA engine: channel registers, arbitration, data mover.
// Assumes a synchronous register port, a memory bus master port that
// answers with ack or err, and peripherals with level requests.
//
// Summary of operation
// - Channel keeps pointer, counter, reloads, peripheral select.
// - Channels keep independent state and requests.
// - Acknowledge pulses when the move has started.
// - Finished flag per channel flags buffer done.
// - Identity code picks peripheral and direction.
// - Pointer advances one, two or four.
// - Nonzero count write starts enabled channel.
// - Counter drops by one per item.
// - Pointer and counter readable while active.
// - Two bus clock run inputs, on after reset.
// - Gated clocks freeze work, then resume.
// - Counter zero with reload nonzero reloads, clears.
// - Lowest numbered channel served first.
// - Memory error flags channel and stops it.
// - Narrow items zero filled into a word.
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module pdma_core (
  input  wire logic                                clock,
  input  wire logic                                rst,
  input  wire logic                                hsbClockRun,
  input  wire logic                                pbClockRun,
  input  wire logic [pdma_pkg::ADDR_W-1:0]         regAddr,
  input  wire logic [31:0]                         regWrData,
  input  wire logic                                regWr,
  input  wire logic                                regRd,
  output logic      [31:0]                         regRdData,
  output logic                                     memReq,
  output logic                                     memWe,
  output logic      [31:0]                         memAddr,
  output logic      [1:0]                          memSize,
  output logic      [31:0]                         memWrData,
  input  wire logic [31:0]                         memRdData,
  input  wire logic                                memAck,
  input  wire logic                                memErr,
  input  wire logic [pdma_pkg::NUM_PER-1:0]        periphReq,
  output logic      [pdma_pkg::NUM_PER-1:0]        periphAck,
  output logic      [pdma_pkg::PER_IDX_W-1:0]      periphSel,
  output logic                                     periphRd,
  output logic                                     periphWr,
  output logic      [31:0]                         periphWrData,
  input  wire logic [31:0]                         periphRdData,
  output logic      [pdma_pkg::NUM_CH-1:0]         xferFinish
);
  import pdma_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0]          mar_q  [NUM_CH];
  logic [15:0]          tcr_q  [NUM_CH];
  logic [31:0]          memory_pointer_reload_q [NUM_CH];
  logic [15:0]          transfer_counter_reload_q [NUM_CH];
  logic [PID_W-1:0]     psr_q  [NUM_CH];
  pdma_size_e           mr_q   [NUM_CH];
  logic                 en_q   [NUM_CH];
  logic                 transfer_error_flag_q [NUM_CH];
  logic                 fin_q  [NUM_CH];
  logic [NUM_CH-1:0]    chReq;

  pdma_state_e          state_q;
  logic [CH_IDX_W-1:0]  chSel_q;
  logic                 toPer_q;
  logic [31:0]          data_q;
  logic [31:0]          regRdData_q;
  logic                 memReq_q;
  logic                 memWe_q;
  logic [31:0]          memAddr_q;
  logic [1:0]           memSize_q;
  logic [31:0]          memWrData_q;
  logic [NUM_PER-1:0]   periphAck_q;
  logic [PER_IDX_W-1:0] periphSel_q;
  logic                 periphRd_q;
  logic                 periphWr_q;
  logic [31:0]          periphWrData_q;

  // ----------------------------------------------------------------
  // Shared decode
  // ----------------------------------------------------------------
  // Both clocks must run; a gated clock simply freezes the mover
  wire                 run     = hsbClockRun & pbClockRun;
  wire [CH_IDX_W-1:0]  rgCh    = regAddr[7:6];
  wire [5:0]           rgOfs   = regAddr[5:0];
  wire                 inDone  = (state_q == PDMA_DONE) && run;
  wire                 memResp = (state_q == PDMA_MEM) && run && (memAck || memErr);
  wire                 errResp = memResp && memErr;
  wire [31:0]          actMar  = mar_q[chSel_q];
  wire [15:0]          actTcr  = tcr_q[chSel_q];
  wire [15:0]          actTcrr = transfer_counter_reload_q[chSel_q];
  wire [2:0]           stepBytes;
  wire [31:0]          sizedData;
  wire [CH_IDX_W-1:0]  grantIdx;
  wire                 grantValid;

  // Peripheral data on the way in, memory data on the way out
  wire [31:0] rawData = (state_q == PDMA_PERRD) ? periphRdData : memRdData;

  pdma_size_align u_align (
    .sizeSel   (mr_q[chSel_q]),
    .rawData   (rawData),
    .sizedData (sizedData),
    .stepBytes (stepBytes)
  );

  pdma_prio_arb u_arb (
    .req        (chReq),
    .grantIdx   (grantIdx),
    .grantValid (grantValid)
  );

  // ----------------------------------------------------------------
  // Per channel registers
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    wire hit     = regWr && (rgCh == CH_IDX_W'(c));
    wire wrMar   = hit && (rgOfs == OFS_MAR);
    wire wrPsr   = hit && (rgOfs == OFS_PSR);
    wire wrTcr   = hit && (rgOfs == OFS_TCR);
    wire wrMarr  = hit && (rgOfs == OFS_MEMORY_POINTER_RELOAD);
    wire wrTcrr  = hit && (rgOfs == OFS_TRANSFER_COUNTER_RELOAD);
    wire wrCr    = hit && (rgOfs == OFS_CR);
    wire wrMr    = hit && (rgOfs == OFS_MR);
    wire mine    = (chSel_q == CH_IDX_W'(c));
    wire doneMe  = inDone && mine;
    wire errMe   = errResp && mine;
    wire [15:0] tcrDec = tcr_q[c] - 16'h0001;
    wire reload  = doneMe && (tcrDec == 16'h0000) && (transfer_counter_reload_q[c] != 16'h0000);
    // Loading the reload pair into an empty channel starts it at once
    wire autoLd  = wrTcrr && (tcr_q[c] == 16'h0000) && !doneMe;
    wire [PER_IDX_W-1:0] perIdx = psr_q[c][PER_IDX_W-1:0];

    // Request needs enable, no error, items left and a raised line
    assign chReq[c] = run && en_q[c] && !transfer_error_flag_q[c]
                      && (tcr_q[c] != 16'h0000)
                      && periphReq[perIdx];
    assign xferFinish[c] = fin_q[c];

    // Pointer, counter and reload pair
    always_ff @(posedge clock) begin
      if (rst) begin
        mar_q[c]  <= PTR_RST;
        tcr_q[c]  <= CNT_RST;
        memory_pointer_reload_q[c] <= PTR_RST;
        transfer_counter_reload_q[c] <= CNT_RST;
      end else begin
        if (reload) begin
          mar_q[c]  <= memory_pointer_reload_q[c];
          tcr_q[c]  <= transfer_counter_reload_q[c];
          memory_pointer_reload_q[c] <= PTR_RST;
          transfer_counter_reload_q[c] <= CNT_RST;
        end else if (doneMe) begin
          mar_q[c] <= mar_q[c] + {29'h0000_0000, stepBytes};
          tcr_q[c] <= tcrDec;
        end
        // Software writes land after the mover's update
        if (wrMar) mar_q[c] <= regWrData;
        if (wrTcr) tcr_q[c] <= regWrData[15:0];
        if (wrMarr) memory_pointer_reload_q[c] <= regWrData;
        if (autoLd) begin
          tcr_q[c]  <= regWrData[15:0];
          mar_q[c]  <= memory_pointer_reload_q[c];
          memory_pointer_reload_q[c] <= PTR_RST;
          transfer_counter_reload_q[c] <= CNT_RST;
        end else if (wrTcrr) begin
          transfer_counter_reload_q[c] <= regWrData[15:0];
        end
      end
    end

    // Configuration, enable and error state
    always_ff @(posedge clock) begin
      if (rst) begin
        psr_q[c]  <= PSR_RST;
        mr_q[c]   <= PDMA_SZ_BYTE;
        en_q[c]   <= 1'b0;
        transfer_error_flag_q[c] <= 1'b0;
        fin_q[c]  <= 1'b0;
      end else begin
        if (wrPsr) psr_q[c] <= regWrData[PID_W-1:0];
        if (wrMr) mr_q[c] <= pdma_size_e'(regWrData[1:0]);
        if (wrCr && regWrData[CR_TEN]) en_q[c] <= 1'b1;
        if (wrCr && regWrData[CR_TDIS]) en_q[c] <= 1'b0;   // Disable wins
        if (wrCr && regWrData[CR_ECLR]) transfer_error_flag_q[c] <= 1'b0;
        if (errMe) transfer_error_flag_q[c] <= 1'b1;
        fin_q[c] <= (tcr_q[c] == 16'h0000) && (transfer_counter_reload_q[c] == 16'h0000);
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------
  logic [31:0] isrWord;
  logic [31:0] srWord;

  // Status words built by field position
  always_comb begin
    isrWord           = 32'h0000_0000;
    srWord            = 32'h0000_0000;
    isrWord[ISR_RCZ]  = (transfer_counter_reload_q[rgCh] == 16'h0000);
    isrWord[ISR_TRC]  = fin_q[rgCh];
    isrWord[ISR_TRANSFER_ERROR_FLAG] = transfer_error_flag_q[rgCh];
    srWord[SR_TEN]    = en_q[rgCh];
  end

  // Live pointer and counter, so progress can be watched
  wire [31:0] rdWord =
    (rgOfs == OFS_MAR)  ? mar_q[rgCh] :
    (rgOfs == OFS_TCR)  ? {16'h0000, tcr_q[rgCh]} :
    (rgOfs == OFS_PSR)  ? {28'h000_0000, psr_q[rgCh]} :
    (rgOfs == OFS_MEMORY_POINTER_RELOAD) ? memory_pointer_reload_q[rgCh] :
    (rgOfs == OFS_TRANSFER_COUNTER_RELOAD) ? {16'h0000, transfer_counter_reload_q[rgCh]} :
    (rgOfs == OFS_MR)   ? {30'h0000_0000, mr_q[rgCh]} :
    (rgOfs == OFS_SR)   ? srWord :
    (rgOfs == OFS_ISR)  ? isrWord : 32'h0000_0000;

  // Data stand only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) regRdData_q <= 32'h0000_0000;
    else regRdData_q <= regRd ? rdWord : 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // Mover state machine
  // ----------------------------------------------------------------
  wire [PID_W-1:0]     gPid   = psr_q[grantIdx];
  wire                 gToPer = gPid[PID_DIR_BIT];
  wire [PER_IDX_W-1:0] gPer   = gPid[PER_IDX_W-1:0];
  wire                 start  = (state_q == PDMA_IDLE) && grantValid;

  // One item at a time; a frozen clock holds every mover output steady
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q        <= PDMA_IDLE;
      chSel_q        <= '0;
      toPer_q        <= 1'b0;
      data_q         <= 32'h0000_0000;
      memReq_q       <= 1'b0;
      memWe_q        <= 1'b0;
      memAddr_q      <= 32'h0000_0000;
      memSize_q      <= 2'h0;
      memWrData_q    <= 32'h0000_0000;
      periphAck_q    <= '0;
      periphSel_q    <= '0;
      periphRd_q     <= 1'b0;
      periphWr_q     <= 1'b0;
      periphWrData_q <= 32'h0000_0000;
    end else if (run) begin
      periphAck_q <= '0;
      periphRd_q  <= 1'b0;
      periphWr_q  <= 1'b0;
      unique case (state_q)
        PDMA_IDLE: begin
          if (start) begin
            chSel_q          <= grantIdx;
            toPer_q          <= gToPer;
            periphSel_q      <= gPer;
            periphAck_q[gPer] <= 1'b1;
            memAddr_q        <= mar_q[grantIdx];
            memSize_q        <= mr_q[grantIdx];
            if (gToPer) begin
              memReq_q <= 1'b1;
              memWe_q  <= 1'b0;
              state_q  <= PDMA_MEM;
            end else begin
              periphRd_q <= 1'b1;
              state_q    <= PDMA_PERRD;
            end
          end
        end
        PDMA_PERRD: begin
          data_q      <= sizedData;
          memWrData_q <= sizedData;
          memReq_q    <= 1'b1;
          memWe_q     <= 1'b1;
          state_q     <= PDMA_MEM;
        end
        PDMA_MEM: begin
          if (memAck || memErr) begin
            memReq_q <= 1'b0;
            memWe_q  <= 1'b0;
            if (memErr) begin
              state_q <= PDMA_IDLE;
            end else begin
              data_q <= sizedData;
              if (toPer_q) begin
                periphWr_q     <= 1'b1;
                periphWrData_q <= sizedData;
              end
              state_q <= PDMA_DONE;
            end
          end
        end
        PDMA_DONE: begin
          state_q <= PDMA_IDLE;
        end
      endcase
    end
  end

  assign regRdData    = regRdData_q;
  assign memReq       = memReq_q;
  assign memWe        = memWe_q;
  assign memAddr      = memAddr_q;
  assign memSize      = memSize_q;
  assign memWrData    = memWrData_q;
  assign periphAck    = periphAck_q;
  assign periphSel    = periphSel_q;
  assign periphRd     = periphRd_q;
  assign periphWr     = periphWr_q;
  assign periphWrData = periphWrData_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  wire swTouch = regWr && (rgCh == chSel_q);
  wire actRel  = inDone && (actTcr == 16'h0001) && (actTcrr != 16'h0000);
  wire [NUM_CH-1:0] lowMask = NUM_CH'((1 << grantIdx) - 1);

  chk_ack_single: assert property (@(posedge clock) disable iff (rst)
    $onehot0(periphAck_q)) else $error("more than one acknowledge");
  chk_ack_start: assert property (@(posedge clock) disable iff (rst)
    start && run |=> periphAck_q[periphSel_q] && state_q != PDMA_IDLE)
    else $error("start without acknowledge");
  chk_tcr_step: assert property (@(posedge clock) disable iff (rst)
    inDone && !actRel && !swTouch |=> actTcr == $past(actTcr) - 16'h0001)
    else $error("counter did not drop by one");
  chk_mar_step: assert property (@(posedge clock) disable iff (rst)
    inDone && !actRel && !swTouch
    |=> actMar == $past(actMar) + {29'h0, $past(stepBytes)})
    else $error("pointer step wrong");
  chk_reload_clear: assert property (@(posedge clock) disable iff (rst)
    actRel && !swTouch |=> actTcrr == 16'h0000 && actTcr == $past(actTcrr))
    else $error("reload not taken");
  chk_prio_lowest: assert property (@(posedge clock) disable iff (rst)
    grantValid |-> (chReq & lowMask) == '0) else $error("priority order broken");
  chk_err_stop: assert property (@(posedge clock) disable iff (rst)
    errResp |=> state_q == PDMA_IDLE && transfer_error_flag_q[chSel_q] && !chReq[chSel_q])
    else $error("error did not stop channel");
  chk_zero_idle: assert property (@(posedge clock) disable iff (rst)
    grantValid |-> tcr_q[grantIdx] != 16'h0000 && en_q[grantIdx])
    else $error("served an empty or disabled channel");
  chk_size_fill: assert property (@(posedge clock) disable iff (rst)
    state_q == PDMA_PERRD && run && mr_q[chSel_q] == PDMA_SZ_BYTE
    |=> memWrData_q[31:8] == 24'h00_0000) else $error("byte not zero filled");
  chk_freeze: assert property (@(posedge clock) disable iff (rst)
    !run |=> $stable(state_q) && $stable(memReq_q)) else $error("moved while frozen");

  cov_to_mem: cover property (@(posedge clock) disable iff (rst)
    state_q == PDMA_PERRD ##1 state_q == PDMA_MEM ##[1:20] state_q == PDMA_DONE);
  cov_to_per: cover property (@(posedge clock) disable iff (rst)
    periphWr_q ##1 state_q == PDMA_IDLE);
  cov_reload: cover property (@(posedge clock) disable iff (rst) actRel);
  cov_error: cover property (@(posedge clock) disable iff (rst) errResp);
endmodule
`default_nettype wire

// File: verilog/pdma_pad_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: testbench/pdma_far_model.sv
// Far-side model: memory slave of the system bus and peripheral data source.
// Assumes memReq is a level that the engine holds until it is answered.
`timescale 1ns/1ps
`default_nettype none
module pdma_far_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic [31:0] errAddr,
  input  wire logic        memReq,
  input  wire logic [31:0] memAddr,
  output logic      [31:0] memRdData,
  output logic             memAck,
  output logic             memErr,
  input  wire logic        periphRd,
  output logic      [31:0] periphRdData
);
  logic [2:0] waitQ;
  logic       doneQ;
  // One answer per request, after one or four cycles; idle data keeps changing
  always @(posedge clock) begin
    memAck <= 1'b0;
    memErr <= 1'b0;
    memRdData <= rst ? 32'h0 : ~memRdData;
    if (rst || !memReq) begin
      waitQ <= 3'h0;
      doneQ <= 1'b0;
    end else if (!doneQ) begin
      waitQ <= waitQ + 3'h1;
      if (waitQ == (slow ? 3'h3 : 3'h0)) begin
        doneQ <= 1'b1;
        memAck <= (memAddr != errAddr);
        memErr <= (memAddr == errAddr);
        memRdData <= memAddr ^ 32'h5A5A_0F0F;
      end
    end
  end
  // Holding register shows its data while it is read and the complement of that data otherwise
  assign periphRdData = periphRd ? 32'hC3A5_96F1 : 32'h3C5A_690E;
endmodule
`default_nettype wire

// File: testbench/pdma_core_bench.sv
// Self-checking bench for pdma_core.
// Assumes pdma_far_model stands in for memory and the peripherals.
`timescale 1ns/1ps
`default_nettype none
module pdma_core_bench;
  import pdma_pkg::*;
  localparam logic [31:0] ERR = 32'hDEAD_0000;
  logic clock = 1'b0, rst = 1'b1, hsbRun = 1'b1, pbRun = 1'b1, slow = 1'b0;
  logic regWr = 1'b0, regRd = 1'b0, memReq, memWe, memAck, memErr;
  logic periphRd, periphWr, lastWe;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [NUM_PER-1:0] periphReq = '0, periphAck, ackSeen = '0;
  logic [31:0] regWrData = '0, regRdData, memAddr, memWrData, memRdData;
  logic [31:0] periphWrData, periphRdData, pWrSeen, lastAddr, lastWData, rdVal;
  logic [1:0] memSize, lastSize;
  logic [PER_IDX_W-1:0] periphSel;
  logic [NUM_CH-1:0] xferFinish;
  int checked = 0, mismatches = 0;

  pdma_core dut (.clock(clock), .rst(rst), .hsbClockRun(hsbRun), .pbClockRun(pbRun),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memSize(memSize), .memWrData(memWrData), .memRdData(memRdData), .memAck(memAck),
    .memErr(memErr), .periphReq(periphReq), .periphAck(periphAck), .periphSel(periphSel),
    .periphRd(periphRd), .periphWr(periphWr), .periphWrData(periphWrData),
    .periphRdData(periphRdData), .xferFinish(xferFinish));
  pdma_far_model far (.clock(clock), .rst(rst), .slow(slow), .errAddr(ERR),
    .memReq(memReq), .memAddr(memAddr), .memRdData(memRdData), .memAck(memAck),
    .memErr(memErr), .periphRd(periphRd), .periphRdData(periphRdData));

  // --------------------------------------------------------------
  // Clock, monitors and shared tasks
  // --------------------------------------------------------------
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) begin
    if (memAck) begin
      lastAddr <= memAddr;
      lastWe <= memWe;
      lastWData <= memWrData;
      lastSize <= memSize;
    end
    if (periphWr) pWrSeen <= periphWrData;
    // Cleared in reset so the unknown first edge does not stick
    ackSeen <= rst ? '0 : (ackSeen | periphAck);
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [1:0] c, input logic [5:0] o, input logic [31:0] d);
    regAddr <= {c, o};
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [1:0] c, input logic [5:0] o);
    regAddr <= {c, o};
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 rdVal = regRdData;
    @(posedge clock);
  endtask
  task automatic waitFin(input int c);
    for (int i = 0; i < 200 && xferFinish[c] !== 1'b1; i++) @(posedge clock);
    chk({31'h0, xferFinish[c]}, 32'h1);
  endtask
  task automatic end_sim;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic p2m_byte;
    wr(2'h0, OFS_PSR, 32'h2);
    wr(2'h0, OFS_MAR, 32'h100);
    hsbRun <= 1'b0;
    wr(2'h0, OFS_CR, 32'h1);
    wr(2'h0, OFS_TCR, 32'h2);
    periphReq[2] <= 1'b1;
    repeat (5) @(posedge clock);
    chk({24'h0, ackSeen}, 32'h0);
    hsbRun <= 1'b1;
    pbRun <= 1'b0;
    repeat (3) @(posedge clock);
    chk({24'h0, ackSeen}, 32'h0);
    pbRun <= 1'b1;
    waitFin(0);
    repeat (4) @(posedge clock);
    chk({31'h0, memReq}, 32'h0);
    periphReq[2] <= 1'b0;
    chk({24'h0, ackSeen}, 32'h4);
    chk({29'h0, periphSel}, 32'h2);
    chk({30'h0, lastSize}, 32'h0);
    chk({31'h0, lastWe}, 32'h1);
    chk(lastAddr, 32'h101);
    chk(lastWData, 32'hF1);
    rd(2'h0, OFS_MAR);
    chk(rdVal, 32'h102);
    rd(2'h0, OFS_TCR);
    chk(rdVal, 32'h0);
  endtask
  task automatic reload_word;
    slow <= 1'b1;
    wr(2'h1, OFS_MR, 32'h2);
    wr(2'h1, OFS_PSR, 32'hD);
    wr(2'h1, OFS_MEMORY_POINTER_RELOAD, 32'h200);
    wr(2'h1, OFS_CR, 32'h1);
    wr(2'h1, OFS_TRANSFER_COUNTER_RELOAD, 32'h1);
    rd(2'h1, OFS_MAR);
    chk(rdVal, 32'h200);
    wr(2'h1, OFS_MEMORY_POINTER_RELOAD, 32'h300);
    wr(2'h1, OFS_TRANSFER_COUNTER_RELOAD, 32'h1);
    periphReq[5] <= 1'b1;
    waitFin(1);
    periphReq[5] <= 1'b0;
    chk(lastAddr, 32'h300);
    chk({31'h0, lastWe}, 32'h0);
    chk({30'h0, lastSize}, 32'h2);
    chk(pWrSeen, 32'h5A5A_0C0F);
    rd(2'h1, OFS_MAR);
    chk(rdVal, 32'h304);
    slow <= 1'b0;
  endtask
  task automatic prio;
    for (int c = 2; c < 4; c++) begin
      wr(c[1:0], OFS_PSR, 32'(9 - c));
      wr(c[1:0], OFS_MR, 32'h2);
      wr(c[1:0], OFS_MAR, 32'(c * 256));
      wr(c[1:0], OFS_TCR, 32'h1);
    end
    periphReq[7] <= 1'b1;
    repeat (4) @(posedge clock);
    chk({31'h0, memReq}, 32'h0);
    periphReq[7] <= 1'b0;
    wr(2'h2, OFS_CR, 32'h1);
    wr(2'h3, OFS_CR, 32'h1);
    periphReq[7:6] <= 2'b11;
    for (int i = 0; i < 50 && memAck !== 1'b1; i++) @(posedge clock) #1;
    chk({31'h0, memAck}, 32'h1);
    chk(memAddr, 32'h200);
    waitFin(3);
    periphReq[7:6] <= 2'b00;
    chk(lastAddr, 32'h300);
  endtask
  task automatic error_stop;
    wr(2'h0, OFS_MAR, ERR);
    wr(2'h0, OFS_TCR, 32'h1);
    periphReq[2] <= 1'b1;
    repeat (12) @(posedge clock);
    rd(2'h0, OFS_ISR);
    chk(rdVal, 32'h5);
    rd(2'h0, OFS_MAR);
    chk(rdVal, ERR);
    wr(2'h0, OFS_MAR, 32'h180);
    wr(2'h0, OFS_CR, 32'h100);
    waitFin(0);
    periphReq[2] <= 1'b0;
    rd(2'h0, OFS_MAR);
    chk(rdVal, 32'h181);
  endtask

  // Watchdog far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    end_sim;
  end
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    chk({28'h0, xferFinish}, 32'hF);
    rd(2'h0, OFS_CR);
    chk(rdVal, 32'h0);
    rd(2'h1, 6'h3C);
    chk(rdVal, 32'h0);
    wr(2'h3, OFS_TCR, 32'hFFFF_FFFF);
    rd(2'h3, OFS_TCR);
    chk(rdVal, 32'h0000_FFFF);
    p2m_byte;
    reload_word;
    prio;
    error_stop;
    end_sim;
  end
endmodule
`default_nettype wire
